// [verilog/god_cmd_decoder.sv]
// Command decoder and settings store for a gray-scale matrix display
// Operation
// - Command-select low with write strobe: byte is opcode or parameter.
// - 20h parameter bit 0 picks horizontal or vertical addressing.
// - 21h sets column window start and end, 0 to 79.
// - 22h sets row window start and end, 0 to 159.
// - Row window write loads row pointer; unlocked vertical mode advances, wraps.
// - 25h parameter bit 0 picks normal or portrait addressing.
// - A0h/A1h set column remap from opcode bit 0.
// - A2h parameter loads display start line, reset zero.
// - 40h-7Fh set start line to low six opcode bits.
// - A4h follows RAM, A5h forces all pixels fully on.
// - A6h normal, A7h inverse gray levels.
// - A8h sets multiplex ratio N+1; values 0 to 14 invalid.
// - ADh bit 4 chooses external or internal reference current.
// - AEh display off, AFh display on.
// - BCh low five bits set pre-charge level, reset 11110b.
// - BEh then fifteen bytes load gray level pulse widths 1 to 15.
// - BFh reloads linear table, level n gets 4n.
// - C0h/C8h bit 3 sets row scan direction.
// - D3h sets vertical display offset 0 to 159.
// - D5h low nibble clock divide, high nibble oscillator code.
// - D9h nibbles set phase 1 and 2 lengths; zero invalid.
// - DAh bit 4 odd/even layout, bit 5 left/right swap.
// - FDh bit 2 locks; while locked only FDh is accepted.
`timescale 1ns/100ps
module god_cmd_decoder (
    // Clock and reset
    input  wire logic              ref_clk_i,
    input  wire logic              rst_n_i,
    // Host byte port
    input  wire logic              dc_sel_i,      // 0 = command byte
    input  wire logic              wr_stb_i,      // one cycle per byte
    input  wire logic [7:0]        wr_data_i,
    // Display RAM row stepping
    input  wire logic              row_done_i,    // one row finished
    // Gray table lookup
    input  wire logic [3:0]        gray_idx_i,
    output logic      [6:0]        gray_width_o,
    // Settings
    output god_pkg::god_cfg_s      cfg_o,
    output logic      [7:0]        row_ptr_o,
    output logic                   busy_o         // parameter pending
);
    import god_pkg::*;

    god_state_e  state_r;
    logic [7:0]  opcode_r;
    logic [7:0]  first_r;
    logic [3:0]  gray_cnt_r;
    logic        cmd_byte;
    logic        opc_stb;
    logic        par_stb;
    logic        gray_wr;
    logic        gray_lin;

    // ********************************************************************
    // Byte classification
    // ********************************************************************
    // Data bytes (select high) are RAM traffic and never reach here
    assign cmd_byte = wr_stb_i && !dc_sel_i;
    assign opc_stb  = cmd_byte && (state_r == GOD_IDLE);
    assign par_stb  = cmd_byte && (state_r != GOD_IDLE);

    // State entered after each opcode; one- and two-parameter opcodes both enter GOD_PARM1
    function automatic god_state_e after_opcode(input logic [7:0] op);
        god_state_e nx;
        nx = GOD_IDLE;
        case (op)
            OP_ADDR_MODE, OP_PORTRAIT, OP_START_LINE, OP_MUX, OP_REFERENCE_CURRENT,
            OP_PRECHARGE, OP_OFFSET, OP_CLK_DIV, OP_PHASE, OP_PIN_CFG,
            OP_LOCK, OP_COL_WIN, OP_ROW_WIN: nx = GOD_PARM1;
            OP_GRAY_TABLE:                   nx = GOD_GRAY;
            default:                         nx = GOD_IDLE;
        endcase
        return nx;
    endfunction

    // ********************************************************************
    // Sequencer
    // ********************************************************************
    // Opcodes arriving while locked are dropped unless they are the unlock
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_r    <= GOD_IDLE;
            opcode_r   <= RST_ZERO;
            first_r    <= RST_ZERO;
            gray_cnt_r <= 4'h0;
        end else if (opc_stb) begin
            opcode_r   <= wr_data_i;
            gray_cnt_r <= 4'h1;
            if (!cfg_o.locked || wr_data_i == OP_LOCK) begin
                state_r <= after_opcode(wr_data_i);
            end
        end else if (par_stb) begin
            first_r <= wr_data_i;
            case (state_r)
                GOD_PARM1: begin
                    if (opcode_r == OP_COL_WIN || opcode_r == OP_ROW_WIN) begin
                        state_r <= GOD_PARM2;
                    end else begin
                        state_r <= GOD_IDLE;
                    end
                end
                GOD_PARM2: state_r <= GOD_IDLE;
                GOD_GRAY: begin
                    gray_cnt_r <= gray_cnt_r + 4'h1;
                    if (gray_cnt_r == 4'(GRAY_LEVELS)) begin
                        state_r <= GOD_IDLE;
                    end
                end
                default: state_r <= GOD_IDLE;
            endcase
        end
    end

    // ********************************************************************
    // Single-byte opcodes
    // ********************************************************************
    wire accept = opc_stb && !cfg_o.locked;

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cfg_o.col_remap    <= 1'b0;
            cfg_o.all_on       <= 1'b0;
            cfg_o.inverse      <= 1'b0;
            cfg_o.display_on   <= 1'b0;
            cfg_o.scan_reverse <= 1'b0;
        end else if (accept) begin
            if (wr_data_i[7:1] == OP_COL_REMAP_H) begin
                cfg_o.col_remap <= wr_data_i[BIT_SEL];
            end
            if (wr_data_i[7:1] == OP_ALL_ON_H) begin
                cfg_o.all_on <= wr_data_i[BIT_SEL];
            end
            if (wr_data_i[7:1] == OP_INVERSE_H) begin
                cfg_o.inverse <= wr_data_i[BIT_SEL];
            end
            if (wr_data_i[7:1] == OP_DISP_ON_H) begin
                cfg_o.display_on <= wr_data_i[BIT_SEL];
            end
            if (wr_data_i == OP_SCAN_DIR_A || wr_data_i == OP_SCAN_DIR_B) begin
                cfg_o.scan_reverse <= wr_data_i[BIT_SCAN];
            end
        end
    end

    // ********************************************************************
    // One-parameter settings
    // ********************************************************************
    wire p1 = par_stb && state_r == GOD_PARM1;

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cfg_o.vertical      <= 1'b0;
            cfg_o.portrait      <= 1'b0;
            cfg_o.start_line    <= RST_ZERO;
            cfg_o.mux_ratio     <= ROW_MAX;
            cfg_o.reference_current_internal <= 1'b0;
            cfg_o.precharge     <= RST_PRECHARGE;
            cfg_o.offset        <= RST_ZERO;
            cfg_o.clk_div       <= RST_CLK_DIV;
            cfg_o.osc_freq      <= RST_OSC;
            cfg_o.phase1        <= RST_PHASE1;
            cfg_o.phase2        <= RST_PHASE2;
            cfg_o.odd_even      <= 1'b1;
            cfg_o.lr_swap       <= 1'b0;
            cfg_o.locked        <= 1'b0;
        end else if (accept && wr_data_i[7:6] == OP_SL_SHORT_H) begin
            cfg_o.start_line <= {2'b00, wr_data_i[5:0]};
        end else if (p1) begin
            case (opcode_r)
                OP_ADDR_MODE: cfg_o.vertical <= wr_data_i[BIT_SEL];
                OP_PORTRAIT:  cfg_o.portrait <= wr_data_i[BIT_SEL];
                OP_START_LINE: begin
                    if (wr_data_i <= ROW_MAX) begin
                        cfg_o.start_line <= wr_data_i;
                    end
                end
                OP_MUX: begin
                    if (wr_data_i >= MUX_MIN && wr_data_i <= ROW_MAX) begin
                        cfg_o.mux_ratio <= wr_data_i;
                    end
                end
                OP_REFERENCE_CURRENT: cfg_o.reference_current_internal <= wr_data_i[BIT_REFERENCE_CURRENT];
                OP_PRECHARGE: cfg_o.precharge <= wr_data_i[4:0];
                OP_OFFSET: begin
                    if (wr_data_i <= ROW_MAX) begin
                        cfg_o.offset <= wr_data_i;
                    end
                end
                OP_CLK_DIV: begin
                    cfg_o.clk_div  <= wr_data_i[3:0];
                    cfg_o.osc_freq <= wr_data_i[7:4];
                end
                OP_PHASE: begin
                    if (wr_data_i[3:0] != 4'h0 && wr_data_i[7:4] != 4'h0) begin
                        cfg_o.phase1 <= wr_data_i[3:0];
                        cfg_o.phase2 <= wr_data_i[7:4];
                    end
                end
                OP_PIN_CFG: begin
                    cfg_o.odd_even <= wr_data_i[BIT_ODD_EVEN];
                    cfg_o.lr_swap  <= wr_data_i[BIT_LR_SWAP];
                end
                OP_LOCK: cfg_o.locked <= wr_data_i[BIT_LOCK];
                default: ;
            endcase
        end
    end

    // ********************************************************************
    // Two-parameter windows and row pointer
    // ********************************************************************
    // Both bytes must be in range or the whole window is kept
    wire p2 = par_stb && state_r == GOD_PARM2;

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cfg_o.col_start <= RST_ZERO;
            cfg_o.col_end   <= COL_MAX;
            cfg_o.row_start <= RST_ZERO;
            cfg_o.row_end   <= ROW_MAX;
            row_ptr_o       <= RST_ZERO;
        end else if (p2 && opcode_r == OP_COL_WIN) begin
            if (first_r <= COL_MAX && wr_data_i <= COL_MAX) begin
                cfg_o.col_start <= first_r;
                cfg_o.col_end   <= wr_data_i;
            end
        end else if (p2 && opcode_r == OP_ROW_WIN) begin
            if (first_r <= ROW_MAX && wr_data_i <= ROW_MAX) begin
                cfg_o.row_start <= first_r;
                cfg_o.row_end   <= wr_data_i;
                row_ptr_o       <= first_r;
            end
        end else if (row_done_i && cfg_o.vertical && !cfg_o.locked) begin
            if (row_ptr_o == cfg_o.row_end) begin
                row_ptr_o <= cfg_o.row_start;
            end else begin
                row_ptr_o <= row_ptr_o + 8'h01;
            end
        end
    end

    // Busy while an opcode waits for parameters
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            busy_o <= 1'b0;
        end else if (opc_stb) begin
            busy_o <= (!cfg_o.locked || wr_data_i == OP_LOCK)
                      && after_opcode(wr_data_i) != GOD_IDLE;
        end else if (par_stb) begin
            busy_o <= !(state_r == GOD_PARM2
                      || (state_r == GOD_PARM1 && opcode_r != OP_COL_WIN
                          && opcode_r != OP_ROW_WIN)
                      || (state_r == GOD_GRAY
                          && gray_cnt_r == 4'(GRAY_LEVELS)));
        end
    end

    // ********************************************************************
    // Gray table
    // ********************************************************************
    assign gray_wr  = par_stb && state_r == GOD_GRAY;
    assign gray_lin = accept && wr_data_i == OP_GRAY_LINEAR;

    god_gray_table #(
        .LEVELS (GRAY_LEVELS),
        .WIDTH  (7)
    ) u_gray (
        .ref_clk_i (ref_clk_i),
        .rst_n_i   (rst_n_i),
        .wr_en_i   (gray_wr),
        .wr_idx_i  (gray_cnt_r),
        .wr_data_i (wr_data_i[6:0]),
        .linear_i  (gray_lin),
        .rd_idx_i  (gray_idx_i),
        .rd_data_o (gray_width_o)
    );

    // ********************************************************************
    // Checks
    // ********************************************************************
    a_mux_invalid_kept: assert property (@(posedge ref_clk_i)
        disable iff (!rst_n_i)
        (p1 && opcode_r == OP_MUX && wr_data_i < MUX_MIN)
            |=> $stable(cfg_o.mux_ratio))
        else $error("mux ratio changed on invalid value");

    a_phase_nonzero: assert property (@(posedge ref_clk_i)
        disable iff (!rst_n_i)
        cfg_o.phase1 != 4'h0 && cfg_o.phase2 != 4'h0)
        else $error("phase length became zero");

    a_lock_blocks_on: assert property (@(posedge ref_clk_i)
        disable iff (!rst_n_i)
        (cfg_o.locked && opc_stb) |=> $stable(cfg_o.display_on))
        else $error("display state changed while locked");

    a_display_on_cmd: assert property (@(posedge ref_clk_i)
        disable iff (!rst_n_i)
        (accept && wr_data_i[7:1] == OP_DISP_ON_H)
            |=> cfg_o.display_on == $past(wr_data_i[0]))
        else $error("display on/off not taken");

    a_short_start_line: assert property (@(posedge ref_clk_i)
        disable iff (!rst_n_i)
        (accept && wr_data_i[7:6] == OP_SL_SHORT_H)
            |=> cfg_o.start_line == {2'b00, $past(wr_data_i[5:0])})
        else $error("short start line wrong");

    a_row_ptr_wrap: assert property (@(posedge ref_clk_i)
        disable iff (!rst_n_i)
        (row_done_i && cfg_o.vertical && !cfg_o.locked && !par_stb
            && row_ptr_o == cfg_o.row_end)
            |=> row_ptr_o == $past(cfg_o.row_start))
        else $error("row pointer did not wrap");

    sequence s_gray_open;
        opc_stb && !cfg_o.locked && wr_data_i == OP_GRAY_TABLE;
    endsequence

    a_gray_sequence: assert property (@(posedge ref_clk_i)
        disable iff (!rst_n_i)
        s_gray_open |=> state_r == GOD_GRAY && gray_cnt_r == 4'h1)
        else $error("gray table load did not start");

    a_window_row: assert property (@(posedge ref_clk_i)
        disable iff (!rst_n_i)
        cfg_o.row_end <= ROW_MAX && cfg_o.col_end <= COL_MAX)
        else $error("window out of range");

endmodule : god_cmd_decoder

// [verilog/god_pkg.sv]
// Package: opcodes, field positions, reset values and carrier types
package god_pkg;

    // ********************************************************************
    // Opcodes
    // ********************************************************************
    localparam logic [7:0] OP_ADDR_MODE   = 8'h20;
    localparam logic [7:0] OP_COL_WIN     = 8'h21;
    localparam logic [7:0] OP_ROW_WIN     = 8'h22;
    localparam logic [7:0] OP_PORTRAIT    = 8'h25;
    localparam logic [6:0] OP_COL_REMAP_H = 7'h50;   // A0h/A1h >> 1
    localparam logic [7:0] OP_START_LINE  = 8'hA2;
    localparam logic [1:0] OP_SL_SHORT_H  = 2'h1;    // 40h..7Fh top bits
    localparam logic [6:0] OP_ALL_ON_H    = 7'h52;   // A4h/A5h
    localparam logic [6:0] OP_INVERSE_H   = 7'h53;   // A6h/A7h
    localparam logic [7:0] OP_MUX         = 8'hA8;
    localparam logic [7:0] OP_REFERENCE_CURRENT        = 8'hAD;
    localparam logic [6:0] OP_DISP_ON_H   = 7'h57;   // AEh/AFh
    localparam logic [7:0] OP_PRECHARGE   = 8'hBC;
    localparam logic [7:0] OP_GRAY_TABLE  = 8'hBE;
    localparam logic [7:0] OP_GRAY_LINEAR = 8'hBF;
    localparam logic [7:0] OP_SCAN_DIR_A  = 8'hC0;
    localparam logic [7:0] OP_SCAN_DIR_B  = 8'hC8;
    localparam logic [7:0] OP_OFFSET      = 8'hD3;
    localparam logic [7:0] OP_CLK_DIV     = 8'hD5;
    localparam logic [7:0] OP_PHASE       = 8'hD9;
    localparam logic [7:0] OP_PIN_CFG     = 8'hDA;
    localparam logic [7:0] OP_LOCK        = 8'hFD;

    // ********************************************************************
    // Field positions and limits
    // ********************************************************************
    localparam int         BIT_SEL       = 0;
    localparam int         BIT_REFERENCE_CURRENT      = 4;
    localparam int         BIT_ODD_EVEN  = 4;
    localparam int         BIT_LR_SWAP   = 5;
    localparam int         BIT_LOCK      = 2;
    localparam int         BIT_SCAN      = 3;
    localparam logic [7:0] COL_MAX       = 8'h4F;   // 79
    localparam logic [7:0] ROW_MAX       = 8'h9F;   // 159
    localparam logic [7:0] MUX_MIN       = 8'h0F;   // 15
    localparam int         GRAY_LEVELS   = 15;
    localparam logic [6:0] GRAY_STEP     = 7'h04;

    // ********************************************************************
    // Reset values
    // ********************************************************************
    localparam logic [7:0] RST_ZERO      = 8'h00;
    localparam logic [4:0] RST_PRECHARGE = 5'h1E;
    localparam logic [3:0] RST_CLK_DIV   = 4'h1;
    localparam logic [3:0] RST_OSC       = 4'h4;
    localparam logic [3:0] RST_PHASE1    = 4'h2;
    localparam logic [3:0] RST_PHASE2    = 4'h7;

    // ********************************************************************
    // Types
    // ********************************************************************
    typedef enum logic [2:0] {
        GOD_IDLE  = 3'b000,
        GOD_PARM1 = 3'b001,
        GOD_PARM2 = 3'b010,
        GOD_GRAY  = 3'b011
    } god_state_e;

    // Display settings carried out of the decoder
    typedef struct packed {
        logic       vertical;
        logic       portrait;
        logic [7:0] col_start;
        logic [7:0] col_end;
        logic [7:0] row_start;
        logic [7:0] row_end;
        logic       col_remap;
        logic [7:0] start_line;
        logic       all_on;
        logic       inverse;
        logic [7:0] mux_ratio;
        logic       reference_current_internal;
        logic       display_on;
        logic [4:0] precharge;
        logic       scan_reverse;
        logic [7:0] offset;
        logic [3:0] clk_div;
        logic [3:0] osc_freq;
        logic [3:0] phase1;
        logic [3:0] phase2;
        logic       odd_even;
        logic       lr_swap;
        logic       locked;
    } god_cfg_s;

endpackage : god_pkg

// [verilog/god_gray_table.sv]
// Gray level pulse-width table with registered read port
`timescale 1ns/100ps
module god_gray_table #(
    parameter int LEVELS = 15,
    parameter int WIDTH  = 7
) (
    // Clock and reset
    input  wire logic                      ref_clk_i,
    input  wire logic                      rst_n_i,
    // Write side
    input  wire logic                      wr_en_i,
    input  wire logic [3:0]                wr_idx_i,
    input  wire logic [WIDTH-1:0]          wr_data_i,
    input  wire logic                      linear_i,
    // Read side
    input  wire logic [3:0]                rd_idx_i,
    output logic      [WIDTH-1:0]          rd_data_o
);
    import god_pkg::*;

    logic [WIDTH-1:0] mem_r [1:LEVELS];

    // ********************************************************************
    // Storage; linear reload has priority over a single write
    // ********************************************************************
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            for (int i = 1; i <= LEVELS; i++) begin
                mem_r[i] <= WIDTH'(i * GRAY_STEP);
            end
        end else if (linear_i) begin
            for (int i = 1; i <= LEVELS; i++) begin
                mem_r[i] <= WIDTH'(i * GRAY_STEP);
            end
        end else if (wr_en_i) begin
            mem_r[wr_idx_i] <= wr_data_i;
        end
    end

    // Registered read; level 0 always has no pulse
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rd_data_o <= '0;
        end else if (rd_idx_i == 4'h0) begin
            rd_data_o <= '0;
        end else begin
            rd_data_o <= mem_r[rd_idx_i];
        end
    end

endmodule : god_gray_table

// [tb/god_host_model.sv]
// Host model writing command and parameter bytes
`timescale 1ns/100ps
module god_host_model (
    // Clock
    input  wire logic       ref_clk_i,
    // Byte port
    output logic            dc_sel_o,
    output logic            wr_stb_o,
    output logic [7:0]      wr_data_o
);
    // Idle bus at time zero
    initial begin
        dc_sel_o  = 1'b1;
        wr_stb_o  = 1'b0;
        wr_data_o = 8'h00;
    end
    // One byte a cycle; back-to-back calls keep the strobe up
    task automatic send(input logic dc, input logic [7:0] b);
        @(posedge ref_clk_i);
        dc_sel_o  <= dc;
        wr_stb_o  <= 1'b1;
        wr_data_o <= b;
    endtask : send
    // Release; data inverted so a stale byte never lingers
    task automatic idle();
        @(posedge ref_clk_i);
        wr_stb_o  <= 1'b0;
        dc_sel_o  <= 1'b1;
        wr_data_o <= ~wr_data_o;
    endtask : idle
endmodule : god_host_model

// [tb/test_god_cmd_decoder.sv]
// Self-checking bench for the command decoder
`timescale 1ns/100ps
module test_god_cmd_decoder;
    import god_pkg::*;
    logic        ref_clk_i, rst_n_i, dc_sel, wr_stb, row_done_i, busy_o;
    logic        note_r;
    logic [7:0]  wr_data, row_ptr_o, lfsr_r;
    logic [3:0]  gray_idx_i;
    logic [6:0]  gray_width_o;
    logic [15:0] ops [5] = '{16'hA1A0, 16'hA5A4, 16'hA7A6,
                             16'hAFAE, 16'hC8C0};
    god_cfg_s    cfg_o, exp;
    god_cfg_s    q [$];
    int          n_fail, compares;

    god_host_model i_host (.ref_clk_i(ref_clk_i), .dc_sel_o(dc_sel),
        .wr_stb_o(wr_stb), .wr_data_o(wr_data));
    god_cmd_decoder i_dut (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
        .dc_sel_i(dc_sel), .wr_stb_i(wr_stb), .wr_data_i(wr_data),
        .row_done_i(row_done_i), .gray_idx_i(gray_idx_i),
        .gray_width_o(gray_width_o), .cfg_o(cfg_o), .row_ptr_o(row_ptr_o),
        .busy_o(busy_o));

    // 125 MHz clock
    initial begin
        ref_clk_i = 1'b0;
        forever #4 ref_clk_i = ~ref_clk_i;
    end
    task automatic check(input logic [87:0] got, input logic [87:0] want);
        compares++;
        if (got !== want) begin
            n_fail++;
            $display("wrong value at %0t: got %h want %h", $time, got, want);
        end
    endtask : check
    task automatic conclude();
        if (n_fail == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : conclude
    // Linear feedback sequence, seeded at reset of the bench
    function automatic logic [7:0] nxt();
        lfsr_r = {lfsr_r[6:0], lfsr_r[7] ^ lfsr_r[5] ^ lfsr_r[4] ^ lfsr_r[3]};
        return lfsr_r;
    endfunction : nxt
    task automatic cmd(input logic [7:0] op, input int n,
                       input logic [7:0] a, input logic [7:0] b);
        i_host.send(1'b0, op);
        if (n > 0) i_host.send(1'b0, a);
        // Busy stands from the edge after the opcode until the last byte
        if (n > 0) #1 check(busy_o, 1'b1);
        if (n > 1) i_host.send(1'b0, b);
        i_host.idle();
        #1 check(busy_o, 1'b0);
    endtask : cmd
    // Queue the expectation; watcher compares one edge later
    task automatic note();
        @(posedge ref_clk_i);
        q.push_back(exp);
        note_r <= 1'b1;
        @(posedge ref_clk_i);
        note_r <= 1'b0;
    endtask : note
    always @(posedge ref_clk_i) begin
        if (note_r === 1'b1) check(cfg_o, q.pop_front());
    end
    // Hang guard
    initial begin
        repeat (20000) @(posedge ref_clk_i);
        n_fail++;
        conclude();
    end
    initial begin
        {rst_n_i, row_done_i, gray_idx_i, note_r, n_fail, compares} = '0;
        lfsr_r = 8'h55;
        exp = '0;
        {exp.col_end, exp.row_end, exp.mux_ratio} = {3{ROW_MAX}};
        exp.col_end = COL_MAX;
        {exp.precharge, exp.clk_div, exp.osc_freq} =
            {RST_PRECHARGE, RST_CLK_DIV, RST_OSC};
        {exp.phase1, exp.phase2, exp.odd_even} =
            {RST_PHASE1, RST_PHASE2, 1'b1};
        repeat (6) @(posedge ref_clk_i);
        rst_n_i <= 1'b1;
        note();
        i_host.send(1'b1, 8'hAF);
        i_host.idle();
        note();
        // Every single-byte mode, set then cleared
        for (int k = 0; k < 2; k++) begin
            foreach (ops[i]) cmd(k ? ops[i][7:0] : ops[i][15:8], 0, 0, 0);
            {exp.col_remap, exp.all_on, exp.inverse, exp.display_on,
             exp.scan_reverse} = k ? 5'h00 : 5'h1F;
            note();
        end
        repeat (3) begin
            cmd(OP_REFERENCE_CURRENT, 1, nxt(), 0);
            exp.reference_current_internal = lfsr_r[BIT_REFERENCE_CURRENT];
            cmd(OP_PRECHARGE, 1, nxt(), 0);
            exp.precharge = lfsr_r[4:0];
            cmd(OP_OFFSET, 1, nxt() >> 1, 0);
            exp.offset = lfsr_r >> 1;
            cmd(OP_CLK_DIV, 1, nxt(), 0);
            {exp.osc_freq, exp.clk_div} = lfsr_r;
            cmd(OP_PIN_CFG, 1, nxt(), 0);
            {exp.lr_swap, exp.odd_even} = lfsr_r[5:4];
            cmd(OP_PHASE, 1, nxt() | 8'h11, 0);
            {exp.phase2, exp.phase1} = lfsr_r | 8'h11;
            cmd(OP_PORTRAIT, 1, nxt(), 0);
            exp.portrait = lfsr_r[0];
            cmd(8'h40 | (nxt() & 8'h3F), 0, 0, 0);
            exp.start_line = lfsr_r & 8'h3F;
            note();
        end
        // Boundaries: both phase values have a zero nibble and are refused; elsewhere last legal value kept, the next one refused
        cmd(OP_PHASE, 1, 8'h50, 0);
        cmd(OP_PHASE, 1, 8'h05, 0);
        cmd(OP_MUX, 1, MUX_MIN, 0);
        cmd(OP_MUX, 1, 8'h0E, 0);
        cmd(OP_START_LINE, 1, ROW_MAX, 0);
        cmd(OP_START_LINE, 1, 8'hA0, 0);
        cmd(OP_COL_WIN, 2, 8'h05, COL_MAX);
        cmd(OP_COL_WIN, 2, 8'h06, 8'h50);
        {exp.mux_ratio, exp.start_line} = {MUX_MIN, ROW_MAX};
        {exp.col_start, exp.col_end} = {8'h05, COL_MAX};
        note();
        cmd(OP_ADDR_MODE, 1, 8'h01, 0);
        cmd(OP_ROW_WIN, 2, 8'h02, 8'h03);
        {exp.vertical, exp.row_start, exp.row_end} = {1'b1, 8'h02, 8'h03};
        note();
        // Row pointer steps and wraps to the window start
        for (int i = 0; i < 4; i++) begin
            @(negedge ref_clk_i);
            check(row_ptr_o, 8'h02 + i[0]);
            @(posedge ref_clk_i);
            row_done_i <= 1'b1;
            @(posedge ref_clk_i);
            row_done_i <= 1'b0;
        end
        // While locked, all-on must not take effect
        cmd(OP_LOCK, 1, 8'h04, 0);
        cmd(8'hA5, 0, 0, 0);
        exp.locked = 1'b1;
        note();
        cmd(OP_LOCK, 1, 8'h00, 0);
        exp.locked = 1'b0;
        note();
        // Custom table (top bit must be dropped), then linear reload
        for (int k = 0; k < 2; k++) begin
            i_host.send(1'b0, k ? OP_GRAY_LINEAR : OP_GRAY_TABLE);
            for (int i = 1; i <= 15 && k == 0; i++) begin
                i_host.send(1'b0, 8'h80 | 8'(i * 5));
            end
            i_host.idle();
            for (int i = 0; i < 16; i++) begin
                @(posedge ref_clk_i);
                gray_idx_i <= i[3:0];
                @(posedge ref_clk_i);
                @(negedge ref_clk_i);
                check(gray_width_o, i * (5 - k));
            end
        end
        conclude();
    end
endmodule : test_god_cmd_decoder
